// file: bench/rscd_decoder_assertions.sv
// Port checker for the serial command decoder
`timescale 1ns/10ps
module rscd_decoder_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire logic select_low,
  input wire logic miso_oe,
  input wire logic idle_state,
  input wire logic reg_wr,
  input wire logic tx_wr,
  input wire logic tx_start,
  input wire logic tx_noack,
  input wire logic tx_ack_pl,
  input wire logic tx_flush,
  input wire logic reuse_active,
  input wire logic features_on,
  input wire logic bank_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_oe_select: assert property ($rose(miso_oe) |-> !select_low)
    else $error("miso driven without select");
  a_oe_release: assert property (select_low [*8] |-> !miso_oe)
    else $error("miso still driven");
  a_wr_idle: assert property (!idle_state [*8] |-> !reg_wr)
    else $error("register write while busy");
  a_opt_gate: assert property (
    tx_wr && (tx_noack || tx_ack_pl) |-> features_on)
    else $error("optional load while disabled");
  a_bank_idle: assert property ($changed(bank_sel) |-> idle_state)
    else $error("bank toggled while busy");
  a_feat_idle: assert property (
    $changed(features_on) |-> idle_state)
    else $error("features toggled while busy");
  a_reuse_end: assert property ($fell(reuse_active) |->
    tx_flush || tx_start || $past(tx_flush) || $past(tx_start))
    else $error("repeat ended without cause");
  a_flush_pulse: assert property (tx_flush |=> !tx_flush)
    else $error("flush longer than one cycle");
endmodule // rscd_decoder_assertions
bind rscd_decoder rscd_decoder_assertions u_rscd_decoder_assertions (.*);

// file: bench/rscd_decoder_bench.sv
// Self-checking bench for the serial command decoder
`timescale 1ns/10ps
module rscd_decoder_bench;
  logic clock = 1'h0, rst = 1'h1, clk_en, idle_state;
  logic bank_m = 1'h0, feat_m = 1'h0, select_low, sck, mosi, miso_o;
  logic miso_oe, reg_rd_req, reg_wr, bank_sel, rx_rd_req, rx_pop, tx_wr;
  logic tx_start, tx_noack, tx_ack_pl, tx_flush, rx_flush, reuse_active;
  logic features_on;
  logic [4:0] reg_addr;
  logic [2:0] reg_byte_idx, tx_pipe;
  logic [5:0] rx_head_width;
  logic [7:0] status_byte, reg_rd_data = 8'h00, rx_rd_data = 8'h00;
  logic [7:0] reg_wr_data, tx_wr_data, txb[$], rxb[$];
  logic [19:0] evq[$], expq[$];
  int error_cnt = 0, total_checks = 0;
  always #2.5 clock = ~clock;
  rscd_decoder u_rscd_decoder (.*);
  rscd_host u_rscd_host (.*);
  // Register file and receive queue answers, event log
  always @(posedge clock) begin
    #1;
    if (reg_rd_req) reg_rd_data = {1'h1, reg_addr[3:0], reg_byte_idx};
    if (rx_rd_req) rx_rd_data = rx_rd_data + 8'h11;
    if (reg_wr) evq.push_back({4'h1, reg_addr, reg_byte_idx, reg_wr_data});
    if (tx_wr) evq.push_back({12'h200, tx_wr_data});
    if (tx_start) evq.push_back({12'h300, 3'h0, tx_noack, tx_ack_pl, tx_pipe});
    if (tx_flush) evq.push_back(20'h4_0000);
    if (rx_flush) evq.push_back(20'h5_0000);
    if (rx_pop) evq.push_back(20'h6_0000);
  end
  task automatic chk(input string nm, input logic [19:0] e,
      input logic [19:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(input logic [7:0] c, input string nm);
    logic [7:0] r;
    rxb = {};
    u_rscd_host.open_frame();
    u_rscd_host.xfer(c, r);
    rxb.push_back(r);
    foreach (txb[i]) begin
      u_rscd_host.xfer(txb[i], r);
      rxb.push_back(r);
    end
    u_rscd_host.close_frame();
    chk("events", 20'(expq.size()), 20'(evq.size()));
    foreach (expq[i]) chk(nm, expq[i], evq[i]);
    evq = {};
    expq = {};
    txb = {};
    $display("Test %s done", nm);
  endtask
  task automatic wreg(input logic [4:0] a, input int n, input string nm);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      txb.push_back(d);
      if (idle_state && k < int'(rscd_pkg::REG_MAX_BYTES))
        expq.push_back({4'h1, a, 3'((bank_m && a <= 8) ? 4 - k : k), d});
    end
    run({3'h1, a}, nm);
  endtask
  task automatic rdreg(input logic [4:0] a, input int n, input string nm);
    logic [7:0] e;
    repeat (n) txb.push_back(8'hFF);
    run({3'h0, a}, nm);
    for (int k = 0; k < n; k++) begin
      e = {1'h1, a[3:0], 3'((bank_m && a <= 8) ? 4 - k : k)};
      if (a == 5'h07) e[7] = bank_m;
      chk(nm, 20'(e), 20'(rxb[k + 1]));
    end
  endtask
  task automatic act(input logic [7:0] v, input string nm);
    txb.push_back(v);
    run(rscd_pkg::CMD_ACTIVATE, nm);
    if (idle_state) bank_m ^= (v == rscd_pkg::ACT_BANK);
    if (idle_state) feat_m ^= (v == rscd_pkg::ACT_FEATURES);
    chk("bank", 20'(bank_m), 20'(bank_sel));
    chk("features", 20'(feat_m), 20'(features_on));
  endtask
  task automatic load(input logic [7:0] c, input int n, input string nm);
    logic [7:0] d;
    logic ok;
    ok = feat_m || c == rscd_pkg::CMD_WR_TX;
    if (ok)
      expq.push_back({12'h300, 3'h0, c == rscd_pkg::CMD_NOACK, c[3:0]});
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      txb.push_back(d);
      if (ok) expq.push_back({12'h200, d});
    end
    run(c, nm);
  endtask
  task automatic wid(input string nm);
    txb.push_back(8'hFF);
    run(rscd_pkg::CMD_WIDTH, nm);
    chk(nm, feat_m ? 20'(rx_head_width) : 20'h0, 20'(rxb[1]));
  endtask
  initial begin
    #400_000 error_cnt++;
    give_verdict();
  end
  initial begin
    clk_en = 1'h1;
    idle_state = 1'h1;
    status_byte = 8'h00;
    rx_head_width = 6'h00;
    void'($urandom(32'hff24_d458));
    repeat (6) @(posedge clock);
    #1 rst = 1'h0;
    rx_head_width = 6'($urandom_range(1, 32));
    status_byte = 8'($urandom);
    repeat (4) @(posedge clock);
    run(rscd_pkg::CMD_NOP, "nop");
    chk("status", 20'(status_byte), 20'(rxb[0]));
    wreg(5'h03, 2, "wr_b0");
    rdreg(5'h05, 3, "rd_b0");
    rdreg(5'h07, 1, "rd_r7");
    load(rscd_pkg::CMD_NOACK, 1, "noack_off");
    wid("wid_off");
    act(rscd_pkg::ACT_FEATURES, "act_feat");
    wid("wid_on");
    load(8'hAD, 2, "ack_pl");
    load(rscd_pkg::CMD_NOACK, 1, "noack");
    act(rscd_pkg::ACT_BANK, "bank1");
    wreg(5'h02, 6, "wr_b1");
    rdreg(5'h08, 5, "rd_b1");
    rdreg(5'h09, 2, "rd_b1_hi");
    act(rscd_pkg::ACT_BANK, "bank0");
    @(posedge clock) #1 idle_state = 1'h0;
    wreg(5'h04, 2, "wr_busy");
    act(rscd_pkg::ACT_FEATURES, "act_busy");
    @(posedge clock) #1 idle_state = 1'h1;
    run(8'hF0, "unknown");
    load(rscd_pkg::CMD_WR_TX, 3, "tx_load");
    run(rscd_pkg::CMD_REUSE, "reuse");
    chk("reuse", 20'h1, 20'(reuse_active));
    expq.push_back(20'h4_0000);
    run(rscd_pkg::CMD_FLUSH_TX, "flush_tx");
    chk("reuse", 20'h0, 20'(reuse_active));
    run(rscd_pkg::CMD_REUSE, "reuse2");
    load(rscd_pkg::CMD_WR_TX, 1, "tx_end");
    chk("reuse", 20'h0, 20'(reuse_active));
    u_rscd_host.open_frame();
    u_rscd_host.part(rscd_pkg::CMD_FLUSH_RX, 7);
    u_rscd_host.close_frame();
    chk("cut", 20'h0, 20'(evq.size()));
    $display("Test cut done");
    expq.push_back(20'h5_0000);
    run(rscd_pkg::CMD_FLUSH_RX, "flush_rx");
    // A frame while the clock enable is low must leave no trace
    @(posedge clock) #1 clk_en = 1'h0;
    run(rscd_pkg::CMD_FLUSH_RX, "frozen");
    @(posedge clock) #1 clk_en = 1'h1;
    txb = {8'hFF, 8'hFF};
    expq = {20'h6_0000};
    run(rscd_pkg::CMD_RD_RX, "rx_read");
    chk("rx", 20'h11, 20'(rxb[1]));
    chk("rx", 20'h22, 20'(rxb[2]));
    give_verdict();
  end
endmodule // rscd_decoder_bench

// file: bench/rscd_host.sv
// Host side serial master model, mode 0
`timescale 1ns/10ps
module rscd_host (
  // Serial pins
  output logic select_low,
  output logic sck,
  output logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  initial begin
    select_low = 1'h1;
    sck = 1'h0;
    mosi = 1'h0;
  end
  task automatic open_frame();
    select_low = 1'h0;
    #200;
  endtask
  // Byte sent MSB first, reply sampled on the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #80 sck = 1'h1;
      // A released line reads as the inverse of what was last driven
      rx[i] = miso_oe ? miso_o : ~miso_o;
      #80 sck = 1'h0;
    end
  endtask
  // Only the first nb bits of a byte, for frames cut short
  task automatic part(input logic [7:0] tx, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      mosi = tx[i];
      #80 sck = 1'h1;
      #80 sck = 1'h0;
    end
  endtask
  task automatic close_frame();
    mosi = ~mosi;
    #200 select_low = 1'h1;
    #300;
  endtask
endmodule // rscd_host

// file: design/rscd_decoder.sv
// Serial command decoder: select/clock/data sampling, decode, byte streams
`timescale 1ns/10ps
// Overview of operation
// RQ1 - Select falling edge starts new command word
// RQ2 - Status byte shifts out during command byte
// RQ3 - Command byte arrives MSB first
// RQ4 - Data least byte first, bank0 and 9-14
// RQ5 - Bank one registers 0-8 most byte first
// RQ6 - 000AAAAA reads register, up to five bytes
// RQ7 - 001AAAAA writes register, idle states only
// RQ8 - 01100001 reads receive payload, then removes it
// RQ9 - 10100000 loads transmit payload from byte zero
// RQ10 - 11100001 empties transmit queue
// RQ11 - 11100010 empties receive queue
// RQ12 - 11100011 repeats last payload while enabled
// RQ13 - Repeat ends on payload load or flush; code ends it only on 10100000 and 11100001
// RQ14 - Host never toggles repeat mid-packet
// RQ15 - Activate with 0x73 toggles optional features
// RQ16 - Optional commands disabled: ignore writes, zero reads
// RQ17 - Activate honoured only in idle states
// RQ18 - Activate 0x53 toggles bank, shown status_bank_byte bit7; code inserts it in register 7 bit7 only while bank0 is selected
// RQ19 - 01100000 returns head payload width
// RQ20 - 10101PPP loads acknowledge payload for pipe
// RQ21 - 10110000 loads unacknowledged transmit payload
// RQ22 - 11111111 does nothing, status still shifted
// RQ23 - Unknown or refused commands change nothing
// RQ24 - Select rise ends command, output released
module rscd_decoder (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Serial pins
  input wire logic select_low,
  input wire logic sck,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  // Device state
  input wire logic [7:0] status_byte,
  input wire logic idle_state,
  // Register access, one byte each
  output logic [4:0] reg_addr,
  output logic [2:0] reg_byte_idx,
  output logic reg_rd_req,
  input wire logic [7:0] reg_rd_data,
  output logic reg_wr,
  output logic [7:0] reg_wr_data,
  output logic bank_sel,
  // Payload queues
  output logic rx_rd_req,
  input wire logic [7:0] rx_rd_data,
  input wire logic [5:0] rx_head_width,
  output logic rx_pop,
  output logic tx_wr,
  output logic [7:0] tx_wr_data,
  output logic tx_start,
  output logic tx_noack,
  output logic tx_ack_pl,
  output logic [2:0] tx_pipe,
  output logic tx_flush,
  output logic rx_flush,
  output logic reuse_active,
  output logic features_on
);
  typedef enum {ST_IDLE, ST_CMD, ST_DATA, ST_IGNORE} rscd_state_t;
  typedef enum {OP_NONE, OP_RD_REG, OP_WR_REG, OP_RD_RX, OP_WIDTH,
    OP_WR_TX, OP_ACT} rscd_op_t;

  typedef struct packed {
    logic [2:0] sel_s;
    logic [2:0] sck_s;
    logic [2:0] mosi_s;
    logic sel_l;
    logic sck_l;
    rscd_state_t st;
    rscd_op_t op;
    logic [2:0] bit_cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [2:0] byte_cnt;
    logic msb_order;
    logic rx_read;
    logic miso;
    logic miso_oe;
    logic [4:0] reg_addr;
    logic [2:0] reg_byte_idx;
    logic reg_rd_req;
    logic reg_wr;
    logic [7:0] wr_data;
    logic bank;
    logic rx_rd_req;
    logic rx_pop;
    logic tx_wr;
    logic tx_start;
    logic tx_noack;
    logic tx_ack_pl;
    logic [2:0] tx_pipe;
    logic tx_flush;
    logic rx_flush;
    logic reuse;
    logic feat;
  } rscd_regs_t;

  rscd_regs_t q, d;

  // Byte index as seen by the register map for the given order
  function automatic logic [2:0] map_idx(input logic msb, input logic [2:0] n);
    map_idx = msb ? 3'(rscd_pkg::REG_MAX_BYTES - 3'h1 - n) : n;
  endfunction

  always_comb begin
    logic sel_now, sck_now, mosi_now, sel_fall, sel_rise, sck_rise, sck_fall;
    logic [7:0] cmd;
    logic [7:0] next_out;
    d = q;
    d.sel_s = {q.sel_s[1:0], select_low};
    d.sck_s = {q.sck_s[1:0], sck};
    d.mosi_s = {q.mosi_s[1:0], mosi};
    sel_now = q.sel_l;
    sck_now = q.sck_l;
    mosi_now = q.mosi_s[2];
    if (q.sel_s[2] == q.sel_s[1]) begin
      sel_now = q.sel_s[2];
    end
    if (q.sck_s[2] == q.sck_s[1]) begin
      sck_now = q.sck_s[2];
    end
    d.sel_l = sel_now;
    d.sck_l = sck_now;
    sel_fall = q.sel_l && !sel_now;
    sel_rise = !q.sel_l && sel_now;
    sck_rise = !sel_now && !q.sck_l && sck_now;
    sck_fall = !sel_now && q.sck_l && !sck_now;
    cmd = {q.sh_in[6:0], mosi_now};
    next_out = 8'h00;
    d.reg_rd_req = 1'b0;
    d.reg_wr = 1'b0;
    d.rx_rd_req = 1'b0;
    d.rx_pop = 1'b0;
    d.tx_wr = 1'b0;
    d.tx_start = 1'b0;
    d.tx_flush = 1'b0;
    d.rx_flush = 1'b0;
    if (sel_rise) begin
      d.st = ST_IDLE; // [RQ24]
      d.miso_oe = 1'b0; // [RQ24]
      if (q.rx_read) begin
        d.rx_pop = 1'b1; // [RQ8]
      end
      d.rx_read = 1'b0;
    end else if (sel_fall) begin
      d.st = ST_CMD; // [RQ1]
      d.bit_cnt = 3'h0;
      d.byte_cnt = 3'h0;
      d.sh_out = status_byte; // [RQ2]
      d.miso = status_byte[7];
      d.miso_oe = 1'b1;
      d.op = OP_NONE;
      d.rx_read = 1'b0;
    end else if (sck_fall && q.st != ST_IDLE) begin
      d.miso = q.sh_out[7];
    end else if (sck_rise && q.st != ST_IDLE) begin
      d.sh_in = cmd; // [RQ3]
      d.sh_out = {q.sh_out[6:0], 1'b0}; // [RQ2]
      d.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == rscd_pkg::BYTE_LAST_BIT) begin
        if (q.st == ST_CMD) begin
          d.st = ST_DATA;
          d.reg_addr = cmd[4:0];
          d.msb_order = q.bank && cmd[4:0] <= rscd_pkg::MSB_FIRST_LAST;
          d.reg_byte_idx = map_idx(d.msb_order, 3'h0); // [RQ4] [RQ5]
          if (cmd[7:5] == rscd_pkg::CMD_RD_REG[7:5]) begin
            d.op = OP_RD_REG; // [RQ6]
            d.reg_rd_req = 1'b1;
          end else if (cmd[7:5] == rscd_pkg::CMD_WR_REG[7:5]) begin
            d.op = idle_state ? OP_WR_REG : OP_NONE; // [RQ7]
          end else if (cmd == rscd_pkg::CMD_RD_RX) begin
            d.op = OP_RD_RX; // [RQ8]
            d.rx_read = 1'b1;
            d.rx_rd_req = 1'b1;
          end else if (cmd == rscd_pkg::CMD_WIDTH) begin
            d.op = OP_WIDTH; // [RQ19] [RQ16]
          end else if (cmd == rscd_pkg::CMD_WR_TX
              || (q.feat && cmd == rscd_pkg::CMD_NOACK)
              || (q.feat && cmd[7:3] == rscd_pkg::CMD_ACK_PL[7:3]
              && cmd[2:0] <= rscd_pkg::MAX_PIPE)) begin
            d.op = OP_WR_TX; // [RQ9] [RQ21] [RQ20] [RQ16]
            d.tx_start = 1'b1;
            d.tx_noack = cmd == rscd_pkg::CMD_NOACK;
            d.tx_ack_pl = cmd[7:3] == rscd_pkg::CMD_ACK_PL[7:3];
            d.tx_pipe = cmd[2:0];
            if (cmd == rscd_pkg::CMD_WR_TX) begin
              d.reuse = 1'b0; // [RQ13]
            end
          end else if (cmd == rscd_pkg::CMD_FLUSH_TX) begin
            d.tx_flush = 1'b1; // [RQ10]
            d.reuse = 1'b0; // [RQ13]
          end else if (cmd == rscd_pkg::CMD_FLUSH_RX) begin
            d.rx_flush = 1'b1; // [RQ11]
          end else if (cmd == rscd_pkg::CMD_REUSE) begin
            d.reuse = 1'b1; // [RQ12]
          end else if (cmd == rscd_pkg::CMD_ACTIVATE) begin
            d.op = idle_state ? OP_ACT : OP_NONE; // [RQ17]
          end else begin
            d.st = ST_IGNORE; // [RQ22] [RQ23]
          end
        end else if (q.st == ST_DATA) begin
          d.byte_cnt = q.byte_cnt + 3'h1;
          unique case (q.op)
            OP_WR_REG: begin
              if (q.byte_cnt < rscd_pkg::REG_MAX_BYTES) begin
                d.reg_wr = 1'b1; // [RQ7]
                d.wr_data = cmd;
                d.reg_byte_idx = map_idx(q.msb_order, q.byte_cnt);
              end
            end
            OP_WR_TX: begin
              d.tx_wr = 1'b1; // [RQ9]
              d.wr_data = cmd;
            end
            OP_ACT: begin
              if (q.byte_cnt == 3'h0 && cmd == rscd_pkg::ACT_FEATURES) begin
                d.feat = !q.feat; // [RQ15]
              end
              if (q.byte_cnt == 3'h0 && cmd == rscd_pkg::ACT_BANK) begin
                d.bank = !q.bank; // [RQ18]
              end
            end
            OP_RD_REG: begin
              if (q.byte_cnt < rscd_pkg::REG_MAX_BYTES - 3'h1) begin
                d.reg_byte_idx = map_idx(q.msb_order, q.byte_cnt + 3'h1);
                d.reg_rd_req = 1'b1; // [RQ6]
              end
            end
            OP_RD_RX: d.rx_rd_req = 1'b1; // [RQ8]
            default: ;
          endcase
        end
      end
    end
    // Load read data for the next byte once it has been fetched
    if (q.st == ST_DATA && q.bit_cnt == 3'h0 && !sck_rise && !sck_fall) begin
      unique case (q.op)
        OP_RD_REG: next_out = (q.reg_addr == rscd_pkg::BANK_BIT_REG
          && !q.msb_order && q.reg_byte_idx == 3'h0)
          ? {q.bank, reg_rd_data[rscd_pkg::BANK_BIT_POS-1:0]}
          : reg_rd_data; // [RQ18]
        OP_RD_RX: next_out = rx_rd_data;
        OP_WIDTH: next_out = q.feat ? {2'b00, rx_head_width} : 8'h00;
        default: next_out = 8'h00;
      endcase
      if (q.reg_rd_req || q.rx_rd_req || q.op == OP_WIDTH) begin
        d.sh_out = next_out;
        d.miso = next_out[7];
      end
    end
    if (rst) begin
      d = '0;
      d.sel_s = 3'b111;
      d.sel_l = 1'b1;
      d.st = ST_IDLE;
      d.op = OP_NONE;
    end else if (!clk_en) begin
      d = q;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign miso_o = q.miso;
  assign miso_oe = q.miso_oe;
  assign reg_addr = q.reg_addr;
  assign reg_byte_idx = q.reg_byte_idx;
  assign reg_rd_req = q.reg_rd_req;
  assign reg_wr = q.reg_wr;
  assign reg_wr_data = q.wr_data;
  assign bank_sel = q.bank;
  assign rx_rd_req = q.rx_rd_req;
  assign rx_pop = q.rx_pop;
  assign tx_wr = q.tx_wr;
  assign tx_wr_data = q.wr_data;
  assign tx_start = q.tx_start;
  assign tx_noack = q.tx_noack;
  assign tx_ack_pl = q.tx_ack_pl;
  assign tx_pipe = q.tx_pipe;
  assign tx_flush = q.tx_flush;
  assign rx_flush = q.rx_flush;
  assign reuse_active = q.reuse;
  assign features_on = q.feat;
endmodule // rscd_decoder

// file: design/rscd_pkg.sv
// Constants for the radio serial command decoder
package rscd_pkg;
  localparam logic [7:0] CMD_RD_REG = 8'h00;
  localparam logic [7:0] CMD_WR_REG = 8'h20;
  localparam logic [7:0] CMD_RD_RX = 8'h61;
  localparam logic [7:0] CMD_WIDTH = 8'h60;
  localparam logic [7:0] CMD_WR_TX = 8'hA0;
  localparam logic [7:0] CMD_ACK_PL = 8'hA8;
  localparam logic [7:0] CMD_NOACK = 8'hB0;
  localparam logic [7:0] CMD_FLUSH_TX = 8'hE1;
  localparam logic [7:0] CMD_FLUSH_RX = 8'hE2;
  localparam logic [7:0] CMD_REUSE = 8'hE3;
  localparam logic [7:0] CMD_ACTIVATE = 8'h50;
  localparam logic [7:0] CMD_NOP = 8'hFF;
  localparam logic [7:0] ACT_FEATURES = 8'h73;
  localparam logic [7:0] ACT_BANK = 8'h53;
  localparam logic [2:0] MAX_PIPE = 3'h5;
  localparam logic [4:0] BANK_BIT_REG = 5'h07;
  localparam int BANK_BIT_POS = 7;
  localparam logic [4:0] MSB_FIRST_LAST = 5'h08;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0] REG_MAX_BYTES = 3'h5;
endpackage
